// file: pwm_timebase_regs.vh
/*
 Register offsets, field positions and reset values for the PWM timebase block.
 Included by pwm_timebase_select.v; definitions only.
*/
`ifndef PWM_TIMEBASE_REGS_VH
`define PWM_TIMEBASE_REGS_VH

// Per-timer register group: base = timer index * stride
`define TB_GROUP_STRIDE 8'h04
`define TB_OFF_COUNTER 8'h00
`define TB_OFF_PERIOD 8'h01
`define TB_OFF_CONTROL 8'h02
`define TB_OFF_SHADOW_RD 8'h03
`define TB_OFF_SELECT1 8'h10
`define TB_OFF_STATUS 8'h11

// Control register fields
`define TB_CTL_ON_BIT 7
`define TB_CTL_PRESCALER_SYNC_SEL_BIT 6
`define TB_CTL_CKPS_LSB 0
`define TB_CTL_CKPS_MSB 2

`define TB_RST_COUNTER 8'h00
`define TB_RST_PERIOD 8'hFF
`define TB_RST_CONTROL 8'h00
`define TB_RST_SELECT1 8'h00

// Select field encodings
`define TB_SEL_T2 2'h0
`define TB_SEL_T4 2'h1
`define TB_SEL_T6 2'h2
`define TB_SEL_T8 2'h3

`endif

// file: pwm_timebase_select.v
/*
 PWM timebase block: four 8-bit auto-reload timers with double-buffered
 period, sleep freeze control, and per-unit timer selection.
 Assumes one 25 MHz clock, synchronous reset, a simple register port, and
 sleep, external reset event and timer clock-run indications from the
 same clock domain.
*/
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "pwm_timebase_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// One auto-reload timer; all four share it so their semantics match
module pwm_timebase_timer
(
	input wire clk_i,
	input wire rst_i,
	input wire wr_cnt_i,
	input wire wr_per_i,
	input wire wr_ctl_i,
	input wire [7:0] wdata_i,
	input wire sleep_i,
	input wire ext_reset_event_i,
	input wire clk_src_running_i,
	input wire clk_src_internal_i,
	output wire [7:0] count_o,
	output wire [7:0] period_o,
	output wire [7:0] control_o,
	output wire match_o,
	output wire osc_keep_on_o
);

	reg [7:0] counter_ff;
	reg [7:0] nxt_counter;
	reg [7:0] period_ff;
	reg [7:0] shadow_ff;
	reg [7:0] nxt_shadow;
	reg [7:0] control_ff;
	reg [7:0] presc_ff;
	reg [7:0] nxt_presc;
	reg match_ff;
	wire [2:0] ckps;
	wire timer_on;
	wire prescaler_sync_sel;
	wire [7:0] presc_mask;
	wire run;
	wire presc_roll;
	wire at_period;

	assign ckps = control_ff[`TB_CTL_CKPS_MSB:`TB_CTL_CKPS_LSB];
	assign timer_on = control_ff[`TB_CTL_ON_BIT];
	assign prescaler_sync_sel = control_ff[`TB_CTL_PRESCALER_SYNC_SEL_BIT];
	// Prescale of 2^ckps; ones below the roll point
	assign presc_mask = (8'h01 << ckps) - 8'h01;
	// Frozen in sleep when synced; else needs its source running
	assign run = timer_on && clk_src_running_i && !(sleep_i && prescaler_sync_sel);
	assign presc_roll = run && ((presc_ff & presc_mask) == presc_mask);
	// Compare against the hidden shadow, never the visible period
	assign at_period = (counter_ff == shadow_ff);
	// Oscillator held on only while it feeds a timer counting in sleep
	assign osc_keep_on_o = sleep_i && clk_src_internal_i && timer_on && !prescaler_sync_sel;
	assign count_o = counter_ff;
	assign period_o = period_ff;
	assign control_o = control_ff;
	assign match_o = match_ff;

	////////////////////////////////////////////////////////////////////////////
	// Prescaler restarts on a counter or control write so the first period is whole
	always @*
	begin
		nxt_presc = presc_ff;
		if (wr_cnt_i || wr_ctl_i)
		begin
			nxt_presc = 8'h00;
		end
		else if (run)
		begin
			nxt_presc = presc_ff + 8'h01;
		end
	end

	// Copies take the old period if the period is written in the same cycle
	always @*
	begin
		nxt_shadow = shadow_ff;
		if (wr_cnt_i)
		begin
			nxt_shadow = period_ff;
		end
		else if (wr_ctl_i)
		begin
			nxt_shadow = period_ff;
		end
		else if (ext_reset_event_i)
		begin
			nxt_shadow = period_ff;
		end
		else if (presc_roll && at_period)
		begin
			nxt_shadow = period_ff;
		end
	end

	// A counter write wins over the external event and the count
	always @*
	begin
		nxt_counter = counter_ff;
		if (wr_cnt_i)
		begin
			nxt_counter = wdata_i;
		end
		else if (ext_reset_event_i)
		begin
			nxt_counter = `TB_RST_COUNTER;
		end
		else if (presc_roll && at_period)
		begin
			nxt_counter = 8'h00;
		end
		else if (presc_roll)
		begin
			nxt_counter = counter_ff + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			counter_ff <= `TB_RST_COUNTER;
			period_ff <= `TB_RST_PERIOD;
			shadow_ff <= `TB_RST_PERIOD;
			control_ff <= `TB_RST_CONTROL;
			presc_ff <= 8'h00;
			match_ff <= 1'b0;
		end
		else
		begin
			counter_ff <= nxt_counter;
			shadow_ff <= nxt_shadow;
			presc_ff <= nxt_presc;
			match_ff <= presc_roll && at_period;
			if (wr_per_i)
			begin
				period_ff <= wdata_i;
			end
			if (wr_ctl_i)
			begin
				control_ff <= wdata_i;
			end
		end
	end

endmodule // pwm_timebase_timer

////////////////////////////////////////////////////////////////////////////////
module pwm_timebase_select #(
	parameter NUM_TIMERS = 4,
	parameter NUM_UNITS = 4
)
(
	input wire clk_i,
	input wire rst_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	input wire sleep_i,
	input wire ext_reset_event_i,
	input wire [3:0] clk_src_running_i,
	input wire [3:0] clk_src_internal_i,
	output wire [3:0] osc_keep_on_o,
	output wire [3:0] timer_match_o,
	output wire [31:0] timer_counts_o,
	output wire [7:0] unit_select_o,
	output wire [3:0] unit_match_o,
	output wire [31:0] unit_count_o
);

	wire [31:0] period_bus;
	wire [31:0] control_bus;
	reg [7:0] pwm_timer_select_1_ff;
	reg [7:0] nxt_rdata;
	wire [1:0] acc_tmr;
	wire [1:0] acc_off;
	wire grp_hit;

	assign acc_tmr = addr_i[3:2];
	assign acc_off = addr_i[1:0];
	assign grp_hit = (addr_i[7:4] == 4'h0);

	////////////////////////////////////////////////////////////////////////////
	// Timers: identical per index
	genvar g;
	generate
		for (g = 0; g < NUM_TIMERS; g = g + 1)
		begin : tmr
			wire sel_me;
			wire wr_cnt;
			wire wr_per;
			wire wr_ctl;

			// Strobes for this timer's register group
			assign sel_me = grp_hit && ({30'h0, acc_tmr} == g);
			assign wr_cnt = wr_i && sel_me && (acc_off == 2'h0);
			assign wr_per = wr_i && sel_me && (acc_off == 2'h1);
			assign wr_ctl = wr_i && sel_me && (acc_off == 2'h2);

			// Same timer for every index
			pwm_timebase_timer i_pwm_timebase_timer
			(
				.clk_i(clk_i),
				.rst_i(rst_i),
				.wr_cnt_i(wr_cnt),
				.wr_per_i(wr_per),
				.wr_ctl_i(wr_ctl),
				.wdata_i(wdata_i),
				.sleep_i(sleep_i),
				.ext_reset_event_i(ext_reset_event_i),
				.clk_src_running_i(clk_src_running_i[g]),
				.clk_src_internal_i(clk_src_internal_i[g]),
				.count_o(timer_counts_o[8*g+7:8*g]),
				.period_o(period_bus[8*g+7:8*g]),
				.control_o(control_bus[8*g+7:8*g]),
				.match_o(timer_match_o[g]),
				.osc_keep_on_o(osc_keep_on_o[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Unit timebase selection
	assign unit_select_o = pwm_timer_select_1_ff;
	generate
		for (g = 0; g < NUM_UNITS; g = g + 1)
		begin : unit
			wire [1:0] code;
			reg [7:0] count_ff;
			assign code = pwm_timer_select_1_ff[2*g+1:2*g];
			assign unit_match_o[g] = timer_match_o[code];
			assign unit_count_o[8*g+7:8*g] = count_ff;
			// Registered copy: a unit's count lags its timer by one clock
			always @(posedge clk_i)
			begin
				if (rst_i)
				begin
					count_ff <= `TB_RST_COUNTER;
				end
				else
				begin
					count_ff <= timer_counts_o[{code, 3'h0} +: 8];
				end
			end
		end
	endgenerate

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pwm_timer_select_1_ff <= `TB_RST_SELECT1;
		end
		else if (wr_i && (addr_i == `TB_OFF_SELECT1))
		begin
			pwm_timer_select_1_ff <= wdata_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port; shadow is not readable, so its slot reads zero
	always @*
	begin
		nxt_rdata = 8'h00;
		if (grp_hit)
		begin
			case (acc_off)
				2'h0:
				begin
					nxt_rdata = timer_counts_o[{acc_tmr, 3'h0} +: 8];
				end
				2'h1:
				begin
					nxt_rdata = period_bus[{acc_tmr, 3'h0} +: 8];
				end
				2'h2:
				begin
					nxt_rdata = control_bus[{acc_tmr, 3'h0} +: 8];
				end
				default:
				begin
					nxt_rdata = 8'h00;
				end
			endcase
		end
		else if (addr_i == `TB_OFF_SELECT1)
		begin
			nxt_rdata = pwm_timer_select_1_ff;
		end
		else if (addr_i == `TB_OFF_STATUS)
		begin
			nxt_rdata = {4'h0, timer_match_o};
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rdata_o <= 8'h00;
		end
		else if (rd_i)
		begin
			rdata_o <= nxt_rdata;
		end
		else
		begin
			// Read data stands one cycle only, then returns to zero
			rdata_o <= 8'h00;
		end
	end

endmodule // pwm_timebase_select

// file: pwm_timebase_select_sva.sv
/* Port checker for pwm_timebase_select; assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module pwm_timebase_sva (
	input clk_i, rst_i, wr_i, rd_i, sleep_i, ext_reset_event_i,
	input [7:0] addr_i, wdata_i, rdata_o, unit_select_o,
	input [3:0] clk_src_internal_i, osc_keep_on_o, timer_match_o, unit_match_o,
	input [31:0] timer_counts_o
);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
property p_hid; rd_i && addr_i == 8'h03 |=> rdata_o == 8'h00; endproperty
a_hid: assert property (p_hid) else $error("shadow read");
property p_cwr; wr_i && addr_i == 8'h00 |=> timer_counts_o[7:0] == $past(wdata_i); endproperty
a_cwr: assert property (p_cwr) else $error("counter write");
// Match is registered on the wrap edge, so both show together
property p_wrap; timer_match_o[0] && !$past(wr_i && addr_i == 8'h00) |-> timer_counts_o[7:0] == 8'h00; endproperty
a_wrap: assert property (p_wrap) else $error("no wrap");
property p_ext; ext_reset_event_i && !wr_i |=> timer_counts_o == 32'h0; endproperty
a_ext: assert property (p_ext) else $error("ext event");
property p_osc; (osc_keep_on_o & ~(clk_src_internal_i & {4{sleep_i}})) == 4'h0; endproperty
a_osc: assert property (p_osc) else $error("osc request");
property p_umt; unit_match_o[3] == timer_match_o[unit_select_o[7:6]]; endproperty
a_umt: assert property (p_umt) else $error("unit match");
property p_sel; wr_i && addr_i == 8'h10 |=> unit_select_o == $past(wdata_i); endproperty
a_sel: assert property (p_sel) else $error("select write");
property p_wr8; timer_match_o[3] && !$past(wr_i && addr_i == 8'h0C) |-> timer_counts_o[31:24] == 8'h00; endproperty
a_wr8: assert property (p_wr8) else $error("no wrap t8");
cover property (timer_match_o[0] && sleep_i);
cover property (ext_reset_event_i);
cover property (timer_match_o[3]);
endmodule // pwm_timebase_sva
bind pwm_timebase_select pwm_timebase_sva i_pwm_timebase_sva (.*);

// file: pwm_timebase_select_tb.sv
/* Bench for pwm_timebase_select; drives the register port and side inputs itself. */
`timescale 1ns/1ps
module pwm_timebase_select_tb;
reg clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, sleep_i = 1'b0, ext_reset_event_i = 1'b0;
reg [7:0] addr_i = 8'h00, wdata_i = 8'h00;
reg [3:0] clk_src_running_i = 4'hF, clk_src_internal_i = 4'h1;
wire [7:0] rdata_o, unit_select_o;
wire [3:0] osc_keep_on_o, timer_match_o, unit_match_o;
wire [31:0] timer_counts_o, unit_count_o;
integer fails = 0, n_checks = 0, n;
always #20 clk_i = ~clk_i;
pwm_timebase_select i_pwm_timebase_select (.*);
////////////////////////////////////////
task chk(input [31:0] s, input [31:0] e, input [31:0] w);
	n_checks = n_checks + 1;
	fails = fails + (s !== e);
	if (s !== e) $display("ERROR %0s expected %0h seen %0h", w, e, s);
endtask
task acc(input r, input [7:0] a, input [7:0] d, input [31:0] w);
	@(posedge clk_i);
	addr_i <= a;
	wdata_i <= d;
	{wr_i, rd_i} <= {!r, r};
	@(posedge clk_i);
	{wr_i, rd_i} <= 2'b00;
	if (r) #1 chk(rdata_o, d, w);
endtask
// Capped so a timer that never matches cannot hang the run
task waitm(input [1:0] t, input [31:0] e, input [31:0] w);
	n = 0;
	while (n == 0 || (timer_match_o[t] !== 1'b1 && n < 300))
		@(posedge clk_i) #1 n = n + 1;
	chk(n, e, w);
endtask
task t_buf;
	acc(1, 8'h10, 8'h00, "sel");
	acc(0, 8'h10, 8'hE4, "");
	acc(1, 8'h03, 8'h00, "shd");
	acc(1, 8'h20, 8'h00, "map");
	acc(0, 8'h01, 8'h05, "");
	acc(0, 8'h02, 8'h80, "");
	waitm(0, 6, "ctl");
	acc(0, 8'h01, 8'h02, "");
	waitm(0, 4, "buf");
	waitm(0, 3, "rel");
	@(posedge clk_i) clk_src_running_i <= 4'hE;
	acc(0, 8'h01, 8'h30, "");
	acc(0, 8'h00, 8'h10, "");
	clk_src_running_i <= 4'hF;
	waitm(0, 33, "cnt");
	acc(0, 8'h01, 8'h03, "");
	ext_reset_event_i <= 1'b1;
	@(posedge clk_i) ext_reset_event_i <= 1'b0;
	waitm(0, 4, "ext");
endtask
task t_run;
	@(posedge clk_i) sleep_i <= 1'b1;
	waitm(0, 3, "slp");
	chk(osc_keep_on_o, 4'h1, "osc");
	acc(0, 8'h02, 8'hC0, "");
	#1 n = timer_counts_o[7:0];
	#320 chk(timer_counts_o[7:0], n, "frz");
	chk(osc_keep_on_o, 4'h0, "psy");
	acc(1, 8'h01, 8'h03, "per");
	acc(0, 8'h10, 8'h24, "");
	@(posedge clk_i) #1 chk(unit_count_o[31:24], n, "u8");
	chk(unit_count_o[7:0], n, "u1");
	acc(0, 8'h0D, 8'h02, "");
	acc(0, 8'h0E, 8'h80, "");
	waitm(3, 3, "t8");
endtask
task stop_test;
	fails = fails + ($time >= 100000);
	$display("checks %0d fails %0d", n_checks, fails);
	if (fails == 0 && n_checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
initial
begin
	repeat (16) @(posedge clk_i);
	rst_i <= 1'b0;
	t_buf;
	t_run;
	stop_test;
end
initial #100000 stop_test;
endmodule // pwm_timebase_select_tb
